// File: core/tsm_etr_filter.sv
// tsm_etr_filter: polarity, prescaler and digital filter for the external trigger
// assumes: pin already synchronised; dtsEn pulses at the dead-time clock rate
`default_nettype none
module tsm_etr_filter
    import tsm_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       pinLevel,
    input  wire logic       polarity,
    input  wire logic [1:0] prescale,
    input  wire logic [3:0] filterCode,
    input  wire logic       dtsEn,
    output logic            filtered
);
    logic       polLevel;
    logic       polPrev_r;
    logic [2:0] pscCnt_r;
    logic       prescaled_r;
    logic [5:0] divCnt_r;
    logic [3:0] evtCnt_r;
    logic [2:0] divLog;
    logic [3:0] needN;
    logic       sampleEn;
    logic [2:0] pscMax;

    // invert when polarity set
    assign polLevel = pinLevel ^ polarity;

    // prescaler output rises once per 2^prescale active edges
    assign pscMax = 3'((4'h1 << prescale) - 4'h1);
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            polPrev_r   <= 1'b0;
            pscCnt_r    <= 3'h0;
            prescaled_r <= 1'b0;
        end
        else
        begin
            polPrev_r <= polLevel;
            if (prescale == 2'h0)
            begin
                pscCnt_r    <= 3'h0; // a later prescale starts from a clean count
                prescaled_r <= polLevel;
            end
            else if (polLevel && !polPrev_r)
            begin
                if (pscCnt_r >= pscMax)
                begin
                    pscCnt_r    <= 3'h0;
                    prescaled_r <= 1'b1;
                end
                else
                begin
                    pscCnt_r <= pscCnt_r + 3'h1;
                    // four bits so the divide-by-eight half point does not wrap
                    if ({1'b0, pscCnt_r} == (({1'b0, pscMax} + 4'h1) >> 1) - 4'h1)
                        prescaled_r <= 1'b0;
                end
            end
        end
    end

    // filter code decode: sampling divider exponent and count
    always_comb
    begin
        divLog = 3'h0;
        needN  = 4'h1;
        case (filterCode)
            4'h0: begin divLog = 3'h0; needN = 4'h1; end
            4'h1: begin divLog = 3'h7; needN = 4'h2; end
            4'h2: begin divLog = 3'h7; needN = 4'h4; end
            4'h3: begin divLog = 3'h7; needN = 4'h8; end
            4'h4: begin divLog = 3'h1; needN = 4'h6; end
            4'h5: begin divLog = 3'h1; needN = 4'h8; end
            4'h6: begin divLog = 3'h2; needN = 4'h6; end
            4'h7: begin divLog = 3'h2; needN = 4'h8; end
            4'h8: begin divLog = 3'h3; needN = 4'h6; end
            4'h9: begin divLog = 3'h3; needN = 4'h8; end
            4'ha: begin divLog = 3'h4; needN = 4'h5; end
            4'hb: begin divLog = 3'h4; needN = 4'h6; end
            4'hc: begin divLog = 3'h4; needN = 4'h8; end
            4'hd: begin divLog = 3'h5; needN = 4'h5; end
            default: begin divLog = 3'h5; needN = 4'h6; end
        endcase
    end

    // sampling enable: kernel clock (divLog 7, filter codes 1 to 3) or dts divided by 2^divLog
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            divCnt_r <= 6'h00;
        else if (dtsEn)
            divCnt_r <= divCnt_r + 6'h01;
    end
    assign sampleEn = (divLog == 3'h7) ? 1'b1 :
                      dtsEn && ((divCnt_r & 6'((7'h01 << divLog) - 7'h01)) == 6'h00);

    // event counter: N agreeing samples validate a transition
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            evtCnt_r <= 4'h0;
            filtered <= 1'b0;
        end
        else if (sampleEn)
        begin
            if (prescaled_r == filtered)
                evtCnt_r <= 4'h0;
            else if (evtCnt_r + 4'h1 >= needN)
            begin
                filtered <= prescaled_r;
                evtCnt_r <= 4'h0;
            end
            else
                evtCnt_r <= evtCnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: core/tsm_host.sv
// tsm_host: software-side driver that programs the controller and drives links
// assumes: user issues one command at a time; keeps source changes to idle mode
`default_nettype none
module tsm_host
    import tsm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    tsm_if.host              bus,
    input  wire logic        cmdWrite,
    input  wire logic        cmdRead,
    input  wire logic [7:0]  cmdAddr,
    input  wire logic [15:0] cmdData,
    input  wire logic [3:0]  userLinks,
    input  wire logic        userEtr,
    input  wire logic        userIn1,
    input  wire logic        userIn2,
    input  wire logic        userEdge,
    input  wire logic [7:0]  userFlags,
    output logic [15:0]      readData,
    output logic             readDone,
    output logic             cmdRefused
);
    logic [15:0] shadow_r;
    logic        refuse;

    // refuse a source change while mode is active, clock2 with source 111 outside mode 111, and gated mode on edge1
    assign refuse = cmdWrite && (cmdAddr == TSM_OFS_SLAVE) &&
        ((shadow_r[TSM_SMC_LSB +: 3] != TSM_SM_OFF &&
          cmdData[TSM_TSS_LSB +: 3] != shadow_r[TSM_TSS_LSB +: 3]) ||
         (cmdData[TSM_EC2_BIT] && cmdData[TSM_TSS_LSB +: 3] == TSM_TS_FILTERED_EXTERNAL_TRIGGER &&
          cmdData[TSM_SMC_LSB +: 3] != TSM_SM_EXT1) ||
         (cmdData[TSM_SMC_LSB +: 3] == TSM_SM_GATED &&
          cmdData[TSM_TSS_LSB +: 3] == TSM_TS_EDGE1));

    // register port drive and link pass-through
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus.wrEn   <= 1'b0;
            bus.rdEn   <= 1'b0;
            bus.addr   <= 8'h00;
            bus.wrData <= 16'h0000;
            shadow_r   <= TSM_RST_SLAVE;
            cmdRefused <= 1'b0;
        end
        else
        begin
            bus.wrEn   <= cmdWrite && !refuse;
            bus.rdEn   <= cmdRead && !cmdWrite;
            cmdRefused <= refuse;
            if (cmdWrite || cmdRead)
            begin
                bus.addr   <= cmdAddr;
                bus.wrData <= cmdData;
            end
            if (cmdWrite && !refuse && cmdAddr == TSM_OFS_SLAVE)
                shadow_r <= cmdData;
        end
    end

    // link levels registered; caller keeps etr rate under quarter clock
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus.internalLink    <= 4'h0;
            bus.extTrigPin      <= 1'b0;
            bus.filteredInput1  <= 1'b0;
            bus.filteredInput2  <= 1'b0;
            bus.ch1EdgeDetector <= 1'b0;
            bus.eventFlags      <= 8'h00;
        end
        else
        begin
            bus.internalLink    <= userLinks;
            bus.extTrigPin      <= userEtr;
            bus.filteredInput1  <= userIn1;
            bus.filteredInput2  <= userIn2;
            bus.ch1EdgeDetector <= userEdge;
            bus.eventFlags      <= userFlags;
        end
    end

    // read return
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            readData <= 16'h0000;
            readDone <= 1'b0;
        end
        else
        begin
            readDone <= bus.rdValid;
            if (bus.rdValid)
                readData <= bus.rdData;
        end
    end
endmodule
`default_nettype wire

// File: core/tsm_if.sv
// tsm_if: register port and trigger links between the driver and the controller
// assumes: one clock; the bench connects both modports
`default_nettype none
interface tsm_if;
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  addr;
    logic [15:0] wrData;
    logic [15:0] rdData;
    logic        rdValid;
    logic [3:0]  internalLink;
    logic        extTrigPin;
    logic        filteredInput1;
    logic        filteredInput2;
    logic        ch1EdgeDetector;
    logic [7:0]  eventFlags;
    modport device (input wrEn, rdEn, addr, wrData, internalLink, extTrigPin,
                    filteredInput1, filteredInput2, ch1EdgeDetector, eventFlags,
                    output rdData, rdValid);
    modport host (output wrEn, rdEn, addr, wrData, internalLink, extTrigPin,
                  filteredInput1, filteredInput2, ch1EdgeDetector, eventFlags,
                  input rdData, rdValid);
endinterface
`default_nettype wire

// File: core/tsm_pkg.sv
// tsm_pkg: shared constants for the timer slave-mode controller and its driver
// assumes: both ends and the bench import this package
`default_nettype none
package tsm_pkg;
    // register offsets and reset values
    localparam logic [7:0]  TSM_OFS_SLAVE   = 8'h08;
    localparam logic [7:0]  TSM_OFS_REQEN   = 8'h0c;
    localparam logic [15:0] TSM_RST_SLAVE   = 16'h0000;
    localparam logic [15:0] TSM_RST_REQEN   = 16'h0000;
    // slave_trigger_control fields
    localparam int TSM_POL_BIT  = 15;
    localparam int TSM_EC2_BIT  = 14;
    localparam int TSM_PSC_LSB  = 12;
    localparam int TSM_FLT_LSB  = 8;
    localparam int TSM_MSS_BIT  = 7;
    localparam int TSM_TSS_LSB  = 4;
    localparam int TSM_SMC_LSB  = 0;
    localparam logic [15:0] TSM_SLAVE_MASK = 16'hfff7; // bit 3 reserved
    localparam logic [15:0] TSM_REQEN_MASK = 16'h7fff; // bit 15 reserved
    localparam int TSM_DMA_LSB  = 8;
    localparam int TSM_NEVT     = 8;  // event flags: 7 break .. 0 update
    // trigger sources
    localparam logic [2:0] TSM_TS_EDGE1 = 3'h4;
    localparam logic [2:0] TSM_TS_IN1   = 3'h5;
    localparam logic [2:0] TSM_TS_IN2   = 3'h6;
    localparam logic [2:0] TSM_TS_FILTERED_EXTERNAL_TRIGGER  = 3'h7;
    // slave modes
    localparam logic [2:0] TSM_SM_OFF   = 3'h0;
    localparam logic [2:0] TSM_SM_ENC1  = 3'h1;
    localparam logic [2:0] TSM_SM_ENC2  = 3'h2;
    localparam logic [2:0] TSM_SM_ENC3  = 3'h3;
    localparam logic [2:0] TSM_SM_RESET = 3'h4;
    localparam logic [2:0] TSM_SM_GATED = 3'h5;
    localparam logic [2:0] TSM_SM_TRIG  = 3'h6;
    localparam logic [2:0] TSM_SM_EXT1  = 3'h7;
    localparam logic [1:0] TSM_CKD_DIV1 = 2'h0;
    localparam logic [1:0] TSM_CKD_DIV2 = 2'h1;
    // filter code table entries: sampling log2 divider and count N
    localparam logic [3:0] TSM_FLT_NONE = 4'h0;
    localparam int TSM_MSM_DELAY = 1;
    typedef enum logic [1:0] {TSM_BUS_IDLE, TSM_BUS_WRITE, TSM_BUS_READ} tsm_bus_e;
endpackage
`default_nettype wire

// File: core/tsm_slave_ctrl.sv
// tsm_slave_ctrl: slave-mode register, trigger selection, mode engine, request gates
// assumes: register port and internal links are same-clock logic; pin inputs are not
`default_nettype none
module tsm_slave_ctrl
    import tsm_pkg::*;
#(
    parameter int NLINK = 4
)
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    tsm_if.device           bus,
    input  wire logic       counterRun,
    input  wire logic [1:0] clockDivision,
    output logic            countPulse,
    output logic            countUp,
    output logic            counterReinit,
    output logic            updateEvent,
    output logic            counterStart,
    output logic            triggerEvent,
    output logic [7:0]      irqReq,
    output logic [6:0]      dmaReq
);
    logic [15:0] slave_r, reqen_r;
    logic [2:0]  etrSync_r, in1Sync_r, in2Sync_r, edgSync_r;
    logic [NLINK-1:0]   lnkLevel;
    logic        etrLevel_r, in1_r, in2_r, edg_r;
    logic [1:0]  dtsCnt_r;
    logic        dtsEn, filtered_external_trigger, etrfPrev_r, trigger_input, trgiPrev_r;
    logic        trgRise, trgEvt, trgDly_r, trgEff;
    logic [2:0]  smc, tss;
    logic        ec2, in1Prev_r, in2Prev_r;

    assign smc = slave_r[TSM_SMC_LSB +: 3];
    assign tss = slave_r[TSM_TSS_LSB +: 3];
    assign ec2 = slave_r[TSM_EC2_BIT];

    // register writes; reserved bits never stored
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slave_r <= TSM_RST_SLAVE;
            reqen_r <= TSM_RST_REQEN;
        end
        else if (bus.wrEn)
        begin
            if (bus.addr == TSM_OFS_SLAVE)
                slave_r <= bus.wrData & TSM_SLAVE_MASK;
            if (bus.addr == TSM_OFS_REQEN)
                reqen_r <= bus.wrData & TSM_REQEN_MASK;
        end
    end

    // register reads, one cycle latency; unmapped read zero
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus.rdData  <= 16'h0000;
            bus.rdValid <= 1'b0;
        end
        else
        begin
            bus.rdValid <= bus.rdEn;
            if (bus.rdEn)
                bus.rdData <= (bus.addr == TSM_OFS_SLAVE) ? slave_r :
                              (bus.addr == TSM_OFS_REQEN) ? reqen_r : 16'h0000;
        end
    end

    // internal links come from sibling timers on this clock, so no synchroniser
    assign lnkLevel = bus.internalLink[NLINK-1:0];
    // three-stage synchronisers; change counts when stages 2 and 3 agree
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            etrSync_r  <= 3'h0;
            in1Sync_r  <= 3'h0;
            in2Sync_r  <= 3'h0;
            edgSync_r  <= 3'h0;
            etrLevel_r <= 1'b0;
            in1_r      <= 1'b0;
            in2_r      <= 1'b0;
            edg_r      <= 1'b0;
        end
        else
        begin
            etrSync_r <= {etrSync_r[1:0], bus.extTrigPin};
            in1Sync_r <= {in1Sync_r[1:0], bus.filteredInput1};
            in2Sync_r <= {in2Sync_r[1:0], bus.filteredInput2};
            edgSync_r <= {edgSync_r[1:0], bus.ch1EdgeDetector};
            if (etrSync_r[1] == etrSync_r[2])
                etrLevel_r <= etrSync_r[2];
            if (in1Sync_r[1] == in1Sync_r[2])
                in1_r <= in1Sync_r[2];
            if (in2Sync_r[1] == in2Sync_r[2])
                in2_r <= in2Sync_r[2];
            if (edgSync_r[1] == edgSync_r[2])
                edg_r <= edgSync_r[2];
        end
    end

    // dead-time sampling clock enable from clock division
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            dtsCnt_r <= 2'h0;
        else
            dtsCnt_r <= dtsCnt_r + 2'h1;
    end
    assign dtsEn = (clockDivision == TSM_CKD_DIV1) ? 1'b1 :
                   (clockDivision == TSM_CKD_DIV2) ? dtsCnt_r[0] : (dtsCnt_r == 2'h3);

    // external trigger conditioning
    tsm_etr_filter uFilter (
        .clock      (clock),
        .reset_n    (reset_n),
        .pinLevel   (etrLevel_r),
        .polarity   (slave_r[TSM_POL_BIT]),
        .prescale   (slave_r[TSM_PSC_LSB +: 2]),
        .filterCode (slave_r[TSM_FLT_LSB +: 4]),
        .dtsEn      (dtsEn),
        .filtered   (filtered_external_trigger)
    );

    // trigger source multiplexer; polarity already applied upstream
    always_comb
    begin
        case (tss)
            TSM_TS_EDGE1: trigger_input = edg_r;
            TSM_TS_IN1:   trigger_input = in1_r;
            TSM_TS_IN2:   trigger_input = in2_r;
            TSM_TS_FILTERED_EXTERNAL_TRIGGER:  trigger_input = filtered_external_trigger;
            default:      trigger_input = lnkLevel[tss[1:0]];
        endcase
    end

    // edge detect and optional sync delay
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trgiPrev_r <= 1'b0;
            etrfPrev_r <= 1'b0;
            trgDly_r   <= 1'b0;
            in1Prev_r  <= 1'b0;
            in2Prev_r  <= 1'b0;
        end
        else
        begin
            trgiPrev_r <= trigger_input;
            etrfPrev_r <= filtered_external_trigger;
            trgDly_r   <= trgEvt;
            in1Prev_r  <= in1_r;
            in2Prev_r  <= in2_r;
        end
    end
    assign trgRise = trigger_input && !trgiPrev_r;
    assign trgEvt  = (smc == TSM_SM_GATED) ? (trigger_input != trgiPrev_r) : trgRise;
    assign trgEff  = slave_r[TSM_MSS_BIT] ? trgDly_r : trgEvt;

    // mode engine: counter strobes, all registered
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            countPulse    <= 1'b0;
            countUp       <= 1'b1;
            counterReinit <= 1'b0;
            updateEvent   <= 1'b0;
            counterStart  <= 1'b0;
            triggerEvent  <= 1'b0;
        end
        else
        begin
            counterReinit <= 1'b0;
            updateEvent   <= 1'b0;
            counterStart  <= 1'b0;
            triggerEvent  <= (smc != TSM_SM_OFF) && trgEff;
            countPulse    <= 1'b0;
            case (smc)
                TSM_SM_OFF:
                    countPulse <= counterRun && !ec2;
                TSM_SM_ENC1:
                begin
                    countPulse <= counterRun && (in2_r != in2Prev_r);
                    countUp    <= in1_r ^ in2_r;
                end
                TSM_SM_ENC2:
                begin
                    countPulse <= counterRun && (in1_r != in1Prev_r);
                    countUp    <= in1_r ^ in2_r ^ 1'b1;
                end
                TSM_SM_ENC3:
                begin
                    countPulse <= counterRun && ((in1_r != in1Prev_r) || (in2_r != in2Prev_r));
                    countUp    <= (in1_r != in1Prev_r) ? !(in1_r ^ in2_r) : (in1_r ^ in2_r);
                end
                TSM_SM_RESET:
                begin
                    counterReinit <= trgEff && (trigger_input || trgDly_r);
                    updateEvent   <= trgEff && (trigger_input || trgDly_r);
                    countPulse    <= counterRun && !ec2;
                end
                TSM_SM_GATED:
                    countPulse <= counterRun && trigger_input && !ec2;
                TSM_SM_TRIG:
                begin
                    counterStart <= trgEff;
                    countPulse   <= counterRun && !ec2;
                end
                TSM_SM_EXT1:
                    countPulse <= counterRun && !ec2 && trgEff;
                default:
                    countPulse <= 1'b0;
            endcase
            // clock2: filtered trigger edges clock counter in any mode except the three encoder modes
            if (ec2 && !(smc == TSM_SM_ENC1 || smc == TSM_SM_ENC2 || smc == TSM_SM_ENC3))
            begin
                // combined with reset/gated/trigger; gating still applies
                countPulse <= counterRun && filtered_external_trigger && !etrfPrev_r
                              && ((smc != TSM_SM_GATED) || trigger_input);
            end
        end
    end

    // request gates: pending flag AND enable
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqReq <= 8'h00;
            dmaReq <= 7'h00;
        end
        else
        begin
            irqReq <= bus.eventFlags & reqen_r[TSM_NEVT-1:0];
            dmaReq <= bus.eventFlags[6:0] & reqen_r[TSM_DMA_LSB +: 7];
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: driver and controller joined by tsm_if, checked against expected read data and strobe counts
// assumes: tsm_pkg, tsm_if, both ends and tsm_sva compiled before
`default_nettype none
module tb_top
    import tsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset_n, cmdWrite, cmdRead, counterRun, userEtr, refusedSeen;
    logic        userIn1, userIn2;
    logic [7:0]  cmdAddr, userFlags;
    logic [15:0] cmdData, readData;
    logic [3:0]  userLinks;
    logic        readDone, cmdRefused, countPulse, countUp, counterReinit;
    logic        updateEvent, counterStart, triggerEvent;
    logic [7:0]  irqReq;
    logic [6:0]  dmaReq;
    int          mismatches, checked, cnt[4];
    logic [15:0] en, w;
    tsm_if bus ();
    tsm_slave_ctrl u_tsm_slave_ctrl (.clock(clock), .reset_n(reset_n), .bus(bus.device),
        .counterRun(counterRun), .clockDivision(2'h0), .countPulse(countPulse),
        .countUp(countUp), .counterReinit(counterReinit), .updateEvent(updateEvent),
        .counterStart(counterStart), .triggerEvent(triggerEvent), .irqReq(irqReq),
        .dmaReq(dmaReq));
    tsm_host u_tsm_host (.clock(clock), .reset_n(reset_n), .bus(bus.host),
        .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .userLinks(userLinks), .userEtr(userEtr), .userIn1(userIn1), .userIn2(userIn2),
        .userEdge(1'b0), .userFlags(userFlags), .readData(readData), .readDone(readDone),
        .cmdRefused(cmdRefused));
    tsm_sva u_tsm_sva (.clock(clock), .reset_n(reset_n), .rdEn(bus.rdEn), .addr(bus.addr),
        .rdData(bus.rdData), .rdValid(bus.rdValid));
    // clock source
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // pulse counters for the counter-control strobes
    always @(posedge clock)
    begin
        cnt[0] += countPulse;
        cnt[1] += counterReinit & updateEvent;
        cnt[2] += counterStart;
        cnt[3] += triggerEvent;
        if (cmdRefused === 1'b1) refusedSeen = 1'b1;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        {cmdWrite, cmdAddr, cmdData} = {1'b1, a, d};
        @(negedge clock);
        cmdWrite = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        int i;
        @(negedge clock);
        {cmdRead, cmdAddr} = {1'b1, a};
        @(negedge clock);
        cmdRead = 1'b0;
        for (i = 0; i < 10 && readDone !== 1'b1; i++) @(negedge clock);
        chk(readData, exp);
    endtask
    task automatic print_verdict;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial
    begin
        #400us;
        mismatches++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        {reset_n, cmdWrite, cmdRead, counterRun, userEtr, refusedSeen} = '0;
        {userIn1, userIn2} = '0;
        {cmdAddr, cmdData, userLinks, userFlags, mismatches, checked} = '0;
        cnt = '{default: 0};
        void'($urandom(1956));
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        rd(TSM_OFS_SLAVE, TSM_RST_SLAVE);
        rd(TSM_OFS_REQEN, TSM_RST_REQEN);
        rd(8'h10, 16'h0000);
        // random register images and request gating
        repeat (8)
        begin
            w = 16'($urandom) & 16'hfff8;
            if (w[6:4] == TSM_TS_FILTERED_EXTERNAL_TRIGGER) w[14] = 1'b0;
            wr(TSM_OFS_SLAVE, w);
            rd(TSM_OFS_SLAVE, w & TSM_SLAVE_MASK);
            en = 16'($urandom);
            userFlags = 8'($urandom);
            wr(TSM_OFS_REQEN, en);
            rd(TSM_OFS_REQEN, en & TSM_REQEN_MASK);
            chk({8'h00, irqReq}, {8'h00, userFlags & en[7:0]});
            chk({9'h000, dmaReq}, {9'h000, userFlags[6:0] & en[14:8]});
        end
        // gated mode on the edge detector is refused and leaves the register alone
        wr(TSM_OFS_SLAVE, 16'h0040);
        wr(TSM_OFS_SLAVE, 16'h0045);
        chk({15'h0000, refusedSeen}, 16'h0001);
        rd(TSM_OFS_SLAVE, 16'h0040);
        // link 0 edges in reset, trigger and clock-one modes; counting needs the run bit
        counterRun = 1'b1;
        wr(TSM_OFS_SLAVE, 16'h0000);
        foreach (cnt[m])
        begin
            if (m == 3) break;
            // trigger mode runs with the sync delay bit set
            wr(TSM_OFS_SLAVE, 16'h0004 + 16'(m < 1 ? 0 : m + 1)
                + (m == 1 ? 16'h0080 : 16'h0000));
            cnt = '{default: 0};
            repeat (3)
            begin
                userLinks[0] = 1'b1;
                repeat (8) @(negedge clock);
                userLinks[0] = 1'b0;
                repeat (8) @(negedge clock);
            end
            chk(16'(cnt[m == 0 ? 1 : (m == 1 ? 2 : 0)]), 16'h0003);
            chk(16'(cnt[3]), 16'h0003);
        end
        // external trigger: polarity, clock two, prescaler
        foreach (cnt[k])
        begin
            wr(TSM_OFS_SLAVE, 16'h0000);
            w = k == 0 ? 16'h0077 : k == 1 ? 16'h8077 : k == 2 ? 16'h4000 : 16'h1077;
            wr(TSM_OFS_SLAVE, w & 16'hfff0);
            wr(TSM_OFS_SLAVE, w);
            repeat (10) @(negedge clock);
            cnt = '{default: 0};
            repeat (7)
            begin
                userEtr = ~userEtr;
                repeat (8) @(negedge clock);
            end
            userEtr = 1'b0;
            repeat (10) @(negedge clock);
            chk(16'(cnt[0]), k == 3 ? 16'h0002 : 16'h0004);
            // mode off with the source kept, so the next source change is legal
            wr(TSM_OFS_SLAVE, w & 16'hfff8);
        end
        // encoder mode one: input 2 edges count, equal levels count down
        wr(TSM_OFS_SLAVE, 16'h0001);
        userIn1 = 1'b1;
        repeat (8) @(negedge clock);
        cnt = '{default: 0};
        repeat (3)
        begin
            userIn2 = ~userIn2;
            repeat (8) @(negedge clock);
        end
        chk(16'(cnt[0]), 16'h0003);
        chk({15'h0000, countUp}, 16'h0000);
        // idle mode with the counter running counts every clock
        wr(TSM_OFS_SLAVE, 16'h0000);
        counterRun = 1'b1;
        repeat (8) @(negedge clock);
        cnt = '{default: 0};
        repeat (20) @(negedge clock);
        chk(16'(cnt[0]), 16'h0014);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: tb/tsm_sva.sv
// tsm_sva: register port checks on the interface between driver and controller
// assumes: instantiated once beside tsm_if in tb_top, single clock domain
`default_nettype none
module tsm_sva
    import tsm_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        rdEn,
    input wire logic [7:0]  addr,
    input wire logic [15:0] rdData,
    input wire logic        rdValid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // a read request on one offset
    sequence s_rd(logic [7:0] a);
        rdEn && addr == a;
    endsequence
    property p_answer;    rdEn |=> rdValid; endproperty
    property p_noask;     rdValid |-> $past(rdEn); endproperty
    property p_rsv_slave; s_rd(TSM_OFS_SLAVE) |=> !rdData[3]; endproperty
    property p_rsv_reqen; s_rd(TSM_OFS_REQEN) |=> !rdData[15]; endproperty
    property p_unmapped;
        rdEn && addr != TSM_OFS_SLAVE && addr != TSM_OFS_REQEN |=> rdData == 16'h0000;
    endproperty
    property p_hold;      !$past(rdEn) |-> $stable(rdData); endproperty
    a_answer:    assert property (p_answer) else $error("read not answered");
    a_noask:     assert property (p_noask) else $error("answer without read");
    a_rsv_slave: assert property (p_rsv_slave) else $error("bit 3 not zero");
    a_rsv_reqen: assert property (p_rsv_reqen) else $error("bit 15 not zero");
    a_unmapped:  assert property (p_unmapped) else $error("unmapped not zero");
    a_hold:      assert property (p_hold) else $error("read data moved");
endmodule
`default_nettype wire
